// ===== src/jtdr_defines.svh
// constants for the boundary-scan test data registers
`ifndef JTDR_DEFINES_SVH
`define JTDR_DEFINES_SVH

// instruction register width and the codes this block decodes
`define JTDR_IR_W 5
`define JTDR_IR_EXTEST 5'h00
`define JTDR_IR_SAMPLE 5'h01
`define JTDR_IR_HIGHZ 5'h0E
`define JTDR_IR_CLAMP 5'h0F
`define JTDR_IR_PROBE 5'h10
`define JTDR_IR_BYPASS 5'h1F

// default structure sizes
`define JTDR_NUM_IO 4
`define JTDR_NUM_CLK 1
`define JTDR_PROBE_LEN 8

// value loaded into the bypass stage on capture
`define JTDR_BYPASS_CAPTURE 1'h0

`endif

// ===== src/jtdr_pkg.sv
// types shared by the boundary-scan test data registers
package jtdr_pkg;

	// tap controller state flags, levels on tck
	typedef struct packed {
		logic tlr;
		logic capture_dr;
		logic shift_dr;
		logic update_dr;
	} jtdr_tap_type;

	// pin drive mode, one-hot
	typedef enum logic [2:0] {
		MODE_NORMAL = 3'h1,
		MODE_DRIVE = 3'h2,
		MODE_HIGHZ = 3'h4
	} jtdr_mode_type;

	// two probe channels
	typedef struct packed {
		logic b;
		logic a;
	} jtdr_probe_type;

endpackage

// ===== src/jtdr_top.sv
// boundary-scan test data registers: bypass, boundary chain and probe-address register
//
// Notes on behaviour
// [R1] one-bit bypass stage between tdi and tdo
// [R2] bypass path for bypass, highz, clamp codes
// [R3] bypass stage loads zero on capture
// [R4] bypass shifts tdi toward tdo in shift
// [R5] bypass stops shifting in update state
// [R6] clock pin cells only observe their pin
// [R7] three chained cells per general io
// [R8] cells have separate update latch output
// [R9] update latches shift stage on falling tck
// [R10] extest captures parallel inputs on capture
// [R11] sample shifts captures out, preload in
// [R12] preloaded latches drive once extest current
// [R13] clamp drives pins from latches, bypass path
// [R14] sample keeps cells transparent to system
// [R15] extest drives latches except in reset
// [R16] extest holds shift stage outside capture/shift
// [R17] code 10000 selects probe-address register
// [R18] probe register length is a parameter
// [R19] address shifted in, stops at update
// [R20] probe result loaded on next capture
// [R21] capture only on valid address; latch on update
// [R22] shift new address in, result out
// [R23] reserved probe pins show result live
// [R24] output-only io drops its input cell
// [R25] code 01110 floats all io outputs
// [R26] code 01111 holds pins at latches
// [R27] test-logic-reset clears probe stages
`timescale 1ns/10ps
`include "jtdr_defines.svh"

module jtdr_top #(
	parameter int NUM_IO = `JTDR_NUM_IO,
	parameter int NUM_CLK = `JTDR_NUM_CLK,
	parameter int PROBE_LEN = `JTDR_PROBE_LEN,
	parameter logic [NUM_IO-1:0] IN_EN = '1
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic tck,
	input wire logic tdi,
	input wire jtdr_pkg::jtdr_tap_type tap,
	input wire logic [`JTDR_IR_W-1:0] instr,
	output logic tdo,
	input wire logic [NUM_CLK-1:0] clk_pin_in,
	input wire logic [NUM_IO-1:0] pad_in,
	input wire logic [NUM_IO-1:0] core_out,
	input wire logic [NUM_IO-1:0] core_oe,
	output logic [NUM_IO-1:0] pad_out,
	output logic [NUM_IO-1:0] pad_oe,
	output logic [NUM_IO-1:0] core_in,
	output logic [PROBE_LEN-1:0] probe_addr,
	input wire jtdr_pkg::jtdr_probe_type probe_result,
	input wire logic probe_addr_valid,
	input wire logic probe_pins_reserved,
	output logic probe_pin_a,
	output logic probe_pin_b
);
	import jtdr_pkg::*;

	localparam int BS_LEN = NUM_CLK + 3 * NUM_IO;

	////////////////////////////////////////////////////////////////////////////////
	// instruction decode

	// boundary chain selected
	function automatic logic sel_boundary(input logic [`JTDR_IR_W-1:0] ir);
		sel_boundary = (ir == `JTDR_IR_EXTEST) || (ir == `JTDR_IR_SAMPLE);
	endfunction

	// probe register selected
	function automatic logic sel_probe_reg(input logic [`JTDR_IR_W-1:0] ir);
		sel_probe_reg = (ir == `JTDR_IR_PROBE);
	endfunction

	logic sel_bs; // boundary chain in path
	logic sel_pr; // probe register in path
	logic sel_byp; // bypass stage in path

	assign sel_bs = sel_boundary(instr);
	assign sel_pr = sel_probe_reg(instr);
	// [R2] bypass for its codes
	assign sel_byp = !sel_bs && !sel_pr;

	////////////////////////////////////////////////////////////////////////////////
	// tck-domain synchronisers for system-side parallel inputs

	logic [NUM_IO-1:0] pad_t1_q, pad_t2_q; // pad values
	logic [NUM_IO-1:0] cout_t1_q, cout_t2_q; // core output values
	logic [NUM_IO-1:0] coe_t1_q, coe_t2_q; // core enable values
	logic [NUM_CLK-1:0] clk_t1_q, clk_t2_q; // clock pin values
	logic [2:0] prb_t1_q, prb_t2_q; // probe result and valid

	// two flip-flops per bit, only the second is read
	always_ff @(posedge tck or negedge resetn) begin
		if (!resetn) begin
			pad_t1_q <= '0;
			pad_t2_q <= '0;
			cout_t1_q <= '0;
			cout_t2_q <= '0;
			coe_t1_q <= '0;
			coe_t2_q <= '0;
			clk_t1_q <= '0;
			clk_t2_q <= '0;
			prb_t1_q <= '0;
			prb_t2_q <= '0;
		end else begin
			pad_t1_q <= pad_in;
			pad_t2_q <= pad_t1_q;
			cout_t1_q <= core_out;
			cout_t2_q <= cout_t1_q;
			coe_t1_q <= core_oe;
			coe_t2_q <= coe_t1_q;
			clk_t1_q <= clk_pin_in;
			clk_t2_q <= clk_t1_q;
			prb_t1_q <= {probe_addr_valid, probe_result};
			prb_t2_q <= prb_t1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// bypass stage

	logic bypass_q; // single bypass bit

	// [R1] shortest serial path
	always_ff @(posedge tck or negedge resetn) begin
		if (!resetn) begin
			bypass_q <= 1'h0;
		end else if (sel_byp && tap.capture_dr) begin
			// [R3] zero on capture
			bypass_q <= `JTDR_BYPASS_CAPTURE;
		end else if (sel_byp && tap.shift_dr) begin
			// [R4] shift tdi through
			bypass_q <= tdi;
		end
		// [R5] update and others hold
	end

	////////////////////////////////////////////////////////////////////////////////
	// boundary-scan chain: tdi -> highest cell ... cell 0 -> tdo

	logic [BS_LEN:0] ser; // serial links between cells
	logic [NUM_CLK-1:0] clk_sr_q; // clock pin capture cells
	logic [NUM_IO-1:0] in_sr_q; // input cell shift stages
	logic [NUM_IO-1:0] out_sr_q; // output cell shift stages
	logic [NUM_IO-1:0] oe_sr_q; // enable cell shift stages
	logic [NUM_IO-1:0] out_lat_q; // output cell update latches
	logic [NUM_IO-1:0] oe_lat_q; // enable cell update latches
	logic bs_cap; // capture this cycle
	logic bs_shift; // shift this cycle

	assign ser[BS_LEN] = tdi;
	// [R16] shift stage moves only in capture or shift
	assign bs_cap = sel_bs && tap.capture_dr && !tap.tlr;
	assign bs_shift = sel_bs && tap.shift_dr && !tap.tlr;

	genvar gk;
	generate
		// [R6] clock cells: capture only, no latch, no drive
		for (gk = 0; gk < NUM_CLK; gk++) begin : g_clk
			assign ser[gk] = clk_sr_q[gk];
			always_ff @(posedge tck or negedge resetn) begin
				if (!resetn) begin
					clk_sr_q[gk] <= 1'h0;
				end else if (bs_cap) begin
					clk_sr_q[gk] <= clk_t2_q[gk];
				end else if (bs_shift) begin
					clk_sr_q[gk] <= ser[gk+1];
				end
			end
		end

		// [R7] per io: input, output, enable cells chained
		for (gk = 0; gk < NUM_IO; gk++) begin : g_io
			localparam int B = NUM_CLK + 3 * gk;
			assign ser[B] = oe_sr_q[gk];
			assign ser[B+1] = out_sr_q[gk];

			// [R10] capture parallel inputs, [R11] shift out and in
			always_ff @(posedge tck or negedge resetn) begin
				if (!resetn) begin
					out_sr_q[gk] <= 1'h0;
					oe_sr_q[gk] <= 1'h0;
				end else if (bs_cap) begin
					out_sr_q[gk] <= cout_t2_q[gk];
					oe_sr_q[gk] <= coe_t2_q[gk];
				end else if (bs_shift) begin
					out_sr_q[gk] <= ser[B+2];
					oe_sr_q[gk] <= ser[B+1];
				end
			end

			// [R8] separate update latch, [R9] loaded on falling tck
			always_ff @(negedge tck or negedge resetn) begin
				if (!resetn) begin
					out_lat_q[gk] <= 1'h0;
					oe_lat_q[gk] <= 1'h0;
				end else if (sel_bs && tap.update_dr) begin
					out_lat_q[gk] <= out_sr_q[gk];
					oe_lat_q[gk] <= oe_sr_q[gk];
				end
			end

			if (IN_EN[gk]) begin : g_in
				assign ser[B+2] = in_sr_q[gk];
				// input cell captures the pad
				always_ff @(posedge tck or negedge resetn) begin
					if (!resetn) begin
						in_sr_q[gk] <= 1'h0;
					end else if (bs_cap) begin
						in_sr_q[gk] <= pad_t2_q[gk];
					end else if (bs_shift) begin
						in_sr_q[gk] <= ser[B+3];
					end
				end
			end else begin : g_no_in
				// [R24] disabled input cell leaves the chain
				assign ser[B+2] = ser[B+3];
				assign in_sr_q[gk] = 1'h0;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// probe-address register

	logic [PROBE_LEN-1:0] pr_sr_q; // shift stage
	logic [PROBE_LEN-1:0] pr_lat_q; // latch stage, drives probe circuitry

	// [R18] length set by PROBE_LEN
	always_ff @(posedge tck or negedge resetn) begin
		if (!resetn) begin
			pr_sr_q <= '0;
		end else if (tap.tlr) begin
			// [R27] cleared in reset state
			pr_sr_q <= '0;
		end else if (sel_pr && tap.capture_dr && prb_t2_q[2]) begin
			// [R20] result loaded on capture, [R21] valid address only
			pr_sr_q <= PROBE_LEN'(prb_t2_q[1:0]);
		end else if (sel_pr && tap.shift_dr) begin
			// [R22] address in, result out
			pr_sr_q <= {tdi, pr_sr_q[PROBE_LEN-1:1]};
		end
		// [R19] update stops the shifting
	end

	// [R21] latch stage takes shift stage in update
	always_ff @(negedge tck or negedge resetn) begin
		if (!resetn) begin
			pr_lat_q <= '0;
		end else if (tap.tlr) begin
			// [R27] latch cleared too
			pr_lat_q <= '0;
		end else if (sel_pr && tap.update_dr) begin
			pr_lat_q <= pr_sr_q;
		end
	end

	assign probe_addr = pr_lat_q;

	////////////////////////////////////////////////////////////////////////////////
	// serial output mux, changes on falling tck

	logic tdo_q; // registered serial output

	// [R17] probe code picks the probe register
	always_ff @(negedge tck or negedge resetn) begin
		if (!resetn) begin
			tdo_q <= 1'h0;
		end else if (sel_bs) begin
			tdo_q <= ser[0];
		end else if (sel_pr) begin
			tdo_q <= pr_sr_q[0];
		end else begin
			tdo_q <= bypass_q;
		end
	end

	assign tdo = tdo_q;

	////////////////////////////////////////////////////////////////////////////////
	// pin mode, tck domain

	jtdr_mode_type mode_q; // how the pins are driven

	// decode mode from the current instruction
	always_ff @(posedge tck or negedge resetn) begin
		if (!resetn) begin
			mode_q <= MODE_NORMAL;
		end else if (tap.tlr) begin
			// [R15] reset state passes inputs through
			mode_q <= MODE_NORMAL;
		end else begin
			case (instr)
				// [R12] extest drives preloaded latches
				`JTDR_IR_EXTEST: mode_q <= MODE_DRIVE;
				// [R13] clamp drives latches, [R26] holds pins
				`JTDR_IR_CLAMP: mode_q <= MODE_DRIVE;
				// [R25] all outputs floated
				`JTDR_IR_HIGHZ: mode_q <= MODE_HIGHZ;
				// [R14] sample and others transparent
				default: mode_q <= MODE_NORMAL;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// ref_clk domain: synchronisers and pin drivers

	logic [2:0] mode_r1_q, mode_r2_q; // mode bits
	logic [NUM_IO-1:0] olat_r1_q, olat_r2_q; // output latches
	logic [NUM_IO-1:0] elat_r1_q, elat_r2_q; // enable latches
	logic [NUM_IO-1:0] pad_r1_q, pad_r2_q; // pad values
	logic [2:0] prb_r1_q, prb_r2_q; // reserve strap and probe result
	logic [NUM_IO-1:0] pad_out_q, pad_oe_q, core_in_q; // pin side outputs
	logic probe_a_q, probe_b_q; // probe pins

	logic tck_r1_q, tck_r2_q, tck_r3_q; // tck level seen from ref_clk
	logic tck_edge; // a tck edge has passed the synchroniser

	// tck is synchronised; its settled edges qualify the tck-domain words
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tck_r1_q <= 1'h0;
			tck_r2_q <= 1'h0;
			tck_r3_q <= 1'h0;
		end else begin
			tck_r1_q <= tck;
			tck_r2_q <= tck_r1_q;
			tck_r3_q <= tck_r2_q;
		end
	end

	// mode and latches move only on tck edges, so they stand still when sampled
	assign tck_edge = tck_r2_q ^ tck_r3_q;

	// words taken on the qualifier, pad and strap bits through two flip-flops
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			mode_r1_q <= MODE_NORMAL;
			mode_r2_q <= MODE_NORMAL;
			olat_r1_q <= '0;
			olat_r2_q <= '0;
			elat_r1_q <= '0;
			elat_r2_q <= '0;
			pad_r1_q <= '0;
			pad_r2_q <= '0;
			prb_r1_q <= '0;
			prb_r2_q <= '0;
		end else begin
			if (tck_edge) begin
				// whole words at once, never a mix of old and new bits
				mode_r1_q <= mode_q;
				olat_r1_q <= out_lat_q;
				elat_r1_q <= oe_lat_q;
			end
			mode_r2_q <= mode_r1_q;
			olat_r2_q <= olat_r1_q;
			elat_r2_q <= elat_r1_q;
			pad_r1_q <= pad_in;
			pad_r2_q <= pad_r1_q;
			prb_r1_q <= {probe_pins_reserved, probe_result};
			prb_r2_q <= prb_r1_q;
		end
	end

	// pad drivers follow the synchronised mode
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pad_out_q <= '0;
			pad_oe_q <= '0;
		end else begin
			case (mode_r2_q)
				MODE_DRIVE: begin
					// [R15] cell outputs from update latches
					pad_out_q <= olat_r2_q;
					pad_oe_q <= elat_r2_q;
				end
				MODE_HIGHZ: begin
					// [R25] every output released
					pad_out_q <= core_out;
					pad_oe_q <= '0;
				end
				default: begin
					// [R14] parallel in equals parallel out
					pad_out_q <= core_out;
					pad_oe_q <= core_oe;
				end
			endcase
		end
	end

	// core sees pads; disabled input cells read zero
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			core_in_q <= '0;
		end else begin
			// [R24] pad input disabled for output-only io
			core_in_q <= pad_r2_q & IN_EN;
		end
	end

	// [R23] live probe result on reserved pins
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			probe_a_q <= 1'h0;
			probe_b_q <= 1'h0;
		end else begin
			probe_a_q <= prb_r2_q[2] & prb_r2_q[0];
			probe_b_q <= prb_r2_q[2] & prb_r2_q[1];
		end
	end

	assign pad_out = pad_out_q;
	assign pad_oe = pad_oe_q;
	assign core_in = core_in_q;
	assign probe_pin_a = probe_a_q;
	assign probe_pin_b = probe_b_q;

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	sequence s_byp_shift;
		sel_byp && tap.shift_dr;
	endsequence

	sequence s_bs_update;
		sel_bs && tap.update_dr;
	endsequence

	a_bypass_zero_load: assert property (@(posedge tck) disable iff (!resetn) // [R3]
		sel_byp && tap.capture_dr |=> bypass_q == 1'h0)
		else $error("bypass stage not zero after capture");

	a_bypass_shift_path: assert property (@(posedge tck) disable iff (!resetn) // [R4]
		s_byp_shift |=> bypass_q == $past(tdi))
		else $error("bypass stage did not take tdi");

	a_bypass_update_hold: assert property (@(posedge tck) disable iff (!resetn) // [R5]
		tap.update_dr && !tap.shift_dr && !tap.capture_dr |=> $stable(bypass_q))
		else $error("bypass stage moved in update");

	a_bs_update_latch: assert property (@(posedge tck) disable iff (!resetn) // [R9]
		s_bs_update |=> out_lat_q == $past(out_sr_q) && oe_lat_q == $past(oe_sr_q))
		else $error("update latch missed shift stage");

	a_bs_capture_core: assert property (@(posedge tck) disable iff (!resetn) // [R10]
		bs_cap |=> out_sr_q == $past(cout_t2_q) && oe_sr_q == $past(coe_t2_q))
		else $error("boundary capture lost parallel inputs");

	a_probe_reset_clear: assert property (@(posedge tck) disable iff (!resetn) // [R27]
		tap.tlr |=> pr_sr_q == '0 && pr_lat_q == '0)
		else $error("probe stages not cleared in reset state");

	a_probe_shift_in: assert property (@(posedge tck) disable iff (!resetn) // [R22]
		sel_pr && tap.shift_dr && !tap.tlr |=> pr_sr_q[PROBE_LEN-1] == $past(tdi))
		else $error("probe register did not shift tdi in");

	a_probe_invalid_hold: assert property (@(posedge tck) disable iff (!resetn) // [R21]
		sel_pr && tap.capture_dr && !tap.shift_dr && !tap.tlr && !prb_t2_q[2]
		|=> $stable(pr_sr_q))
		else $error("probe result captured without valid address");

	a_extest_mode_drive: assert property (@(posedge tck) disable iff (!resetn) // [R15]
		instr == `JTDR_IR_EXTEST && !tap.tlr |=> mode_q == MODE_DRIVE)
		else $error("extest did not select latch drive");

	a_highz_pins_off: assert property (@(posedge ref_clk) disable iff (!resetn) // [R25]
		mode_r2_q == MODE_HIGHZ |=> pad_oe_q == '0)
		else $error("pins driven under highz");

endmodule

// ===== verif/jtdr_tap_model.sv
// test controller model that drives the tap side of the test data registers
`timescale 1ns/10ps
`include "jtdr_defines.svh"

module jtdr_tap_model (
	output logic tck,
	output logic tdi,
	output jtdr_pkg::jtdr_tap_type tap,
	output logic [`JTDR_IR_W-1:0] instr,
	input wire logic tdo
);
	import jtdr_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// idle levels, tck stands still between frames
	initial begin
		tck = 1'b0;
		tdi = 1'b0;
		tap = '0;
		instr = `JTDR_IR_BYPASS;
	end

	// one tck period: change just after the fall, sample tdo before the rise
	task automatic cycle(input jtdr_tap_type st, input logic din, output logic dout);
		#1;
		tap = st;
		tdi = din;
		#79;
		dout = tdo;
		tck = 1'b1;
		#80;
		tck = 1'b0;
	endtask

	// idle cycles; data line toggles so a stale value never looks valid
	task automatic idle(input int n);
		logic d;
		for (int i = 0; i < n; i++) begin
			cycle('0, ~tdi, d);
		end
	endtask

	// new current instruction, then cycles for the mode flop and synchronisers
	task automatic load(input logic [`JTDR_IR_W-1:0] code);
		#1;
		instr = code;
		idle(2);
	endtask

	// one test-logic-reset cycle
	task automatic reset_tap();
		logic d;
		cycle(jtdr_tap_type'(4'h8), ~tdi, d);
	endtask

	// capture, shift n bits lsb first, exit, update, idle
	task automatic scan(input int n, input logic [15:0] din, output logic [15:0] dout);
		logic d;
		dout = '0;
		idle(2);
		cycle(jtdr_tap_type'(4'h4), ~tdi, d);
		for (int i = 0; i < n; i++) begin
			cycle(jtdr_tap_type'(4'h2), din[i], d);
			dout[i] = d;
		end
		cycle('0, ~tdi, d);
		cycle(jtdr_tap_type'(4'h1), ~tdi, d);
		cycle('0, ~tdi, d);
	endtask
endmodule

// ===== verif/jtdr_top_bench.sv
// self-checking bench for the boundary-scan test data registers
`timescale 1ns/10ps
`include "jtdr_defines.svh"

module jtdr_top_bench;
	import jtdr_pkg::*;

	logic ref_clk = 1'b0; // system clock
	logic resetn; // async reset, low active
	logic tck, tdi, tdo; // serial link
	jtdr_tap_type tap; // state flags from the controller model
	logic [4:0] instr; // current instruction
	logic [0:0] clk_pin_in; // clock pin level
	logic [3:0] pad_in, core_out, core_oe; // pin side stimulus
	logic [3:0] pad_out, pad_oe, core_in; // pin side results
	logic [7:0] probe_addr; // probe latch stage
	jtdr_probe_type probe_result; // probe circuit answer
	logic probe_addr_valid, probe_pins_reserved, probe_pin_a, probe_pin_b;
	int bad_count = 0; // mismatches
	int checked = 0; // comparisons
	int cycles = 0; // timeout counter
	logic [15:0] got; // serial result

	////////////////////////////////////////////////////////////////////////////////
	// clocks and instances
	always #2 ref_clk = ~ref_clk;

	jtdr_tap_model u_ctl (.tck(tck), .tdi(tdi), .tap(tap), .instr(instr), .tdo(tdo));

	jtdr_top #(.NUM_IO(4), .NUM_CLK(1), .PROBE_LEN(8), .IN_EN(4'hF)) u_dut (
		.ref_clk(ref_clk), .resetn(resetn), .tck(tck), .tdi(tdi), .tap(tap),
		.instr(instr), .tdo(tdo), .clk_pin_in(clk_pin_in), .pad_in(pad_in),
		.core_out(core_out), .core_oe(core_oe), .pad_out(pad_out), .pad_oe(pad_oe),
		.core_in(core_in), .probe_addr(probe_addr), .probe_result(probe_result),
		.probe_addr_valid(probe_addr_valid), .probe_pins_reserved(probe_pins_reserved),
		.probe_pin_a(probe_pin_a), .probe_pin_b(probe_pin_b)
	);

	////////////////////////////////////////////////////////////////////////////////
	// compare, report, timeout
	task automatic chk_ser(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED serial at %0t: got %h exp %h", $time, g, e);
		end
	endtask

	task automatic chk_pin(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED pins at %0t: got %h exp %h", $time, g, e);
		end
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// hang guard, well above the ~5800 cycles the tests need
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			bad_count++;
			final_report();
		end
	end

	// pin pipeline settle time
	task automatic settle();
		repeat (8) @(posedge ref_clk);
		#1;
	endtask

	// chain image: clock cell 0, then per io enable, output, input
	function automatic logic [15:0] chain(input logic [3:0] oe, input logic [3:0] dout,
			input logic [3:0] din, input logic ck);
		logic [15:0] c;
		c = '0;
		c[0] = ck;
		for (int i = 0; i < 4; i++) begin
			c[3*i+1] = oe[i];
			c[3*i+2] = dout[i];
			c[3*i+3] = din[i];
		end
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_bypass();
		logic [4:0] codes [4];
		codes = '{`JTDR_IR_BYPASS, `JTDR_IR_HIGHZ, `JTDR_IR_CLAMP, 5'h04};
		for (int i = 0; i < 4; i++) begin
			u_ctl.load(codes[i]);
			u_ctl.scan(8, 16'h00B7, got);
			chk_ser(got, 16'h016E & 16'h00FF);
		end
		$display("test bypass done");
	endtask

	task automatic t_boundary();
		logic [15:0] cap;
		@(posedge ref_clk);
		#1;
		pad_in = 4'h9;
		core_out = 4'h6;
		core_oe = 4'hC;
		clk_pin_in = 1'b1;
		cap = chain(4'hC, 4'h6, 4'h9, 1'b1);
		u_ctl.load(`JTDR_IR_SAMPLE);
		u_ctl.scan(13, chain(4'hA, 4'h5, 4'h0, 1'b0), got);
		chk_ser(got, cap);
		settle();
		chk_pin({pad_oe, pad_out}, 8'hC6);
		chk_pin({4'h0, core_in}, 8'h09);
		u_ctl.load(`JTDR_IR_EXTEST);
		settle();
		chk_pin({pad_oe, pad_out}, 8'hA5);
		u_ctl.scan(13, chain(4'hF, 4'h3, 4'h0, 1'b0), got);
		chk_ser(got, cap);
		settle();
		chk_pin({pad_oe, pad_out}, 8'hF3);
		u_ctl.reset_tap();
		settle();
		chk_pin({pad_oe, pad_out}, 8'hC6);
		u_ctl.load(`JTDR_IR_CLAMP);
		settle();
		chk_pin({pad_oe, pad_out}, 8'hF3);
		u_ctl.load(`JTDR_IR_HIGHZ);
		settle();
		chk_pin({pad_oe, pad_out}, 8'h06);
		$display("test boundary done");
	endtask

	task automatic t_probe();
		@(posedge ref_clk);
		#1;
		probe_result = 2'b10;
		probe_addr_valid = 1'b1;
		probe_pins_reserved = 1'b1;
		u_ctl.load(`JTDR_IR_PROBE);
		u_ctl.scan(8, 16'h00A5, got);
		chk_ser(got, 16'h0002);
		chk_ser({8'h00, probe_addr}, 16'h00A5);
		chk_pin({6'h00, probe_pin_b, probe_pin_a}, 8'h02);
		@(posedge ref_clk);
		#1;
		probe_addr_valid = 1'b0;
		probe_pins_reserved = 1'b0;
		u_ctl.scan(8, 16'h003C, got);
		chk_ser(got, 16'h00A5);
		settle();
		chk_pin({6'h00, probe_pin_b, probe_pin_a}, 8'h00);
		u_ctl.reset_tap();
		#1;
		chk_ser({8'h00, probe_addr}, 16'h0000);
		$display("test probe done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		resetn = 1'b0;
		clk_pin_in = 1'b0;
		pad_in = 4'h0;
		core_out = 4'h0;
		core_oe = 4'h0;
		probe_result = '0;
		probe_addr_valid = 1'b0;
		probe_pins_reserved = 1'b0;
		repeat (4) @(posedge ref_clk);
		#1;
		resetn = 1'b1;
		t_bypass();
		t_boundary();
		t_probe();
		final_report();
	end
endmodule
